//--- src/uart_engine.sv
`timescale 1ns/1ps
module uart_engine import uart_pkg::*; #(
   parameter int AW = 4                // Address width
) (
   input  wire logic          aclk,    // CPU clock
   input  wire logic          aresetn, // Sync reset, active low
   input  wire logic [AW-1:0] awaddr,  // Write address
   input  wire logic [2:0]    awprot,  // Unused
   input  wire logic          awvalid, // Write address valid
   output logic               awready, // Write address ready
   input  wire logic [31:0]   wdata,   // Write data
   input  wire logic [3:0]    wstrb,   // Byte enables
   input  wire logic          wvalid,  // Write data valid
   output logic               wready,  // Write data ready
   output logic [1:0]         bresp,   // Write response
   output logic               bvalid,  // Write response valid
   input  wire logic          bready,  // Write response ready
   input  wire logic [AW-1:0] araddr,  // Read address
   input  wire logic [2:0]    arprot,  // Unused
   input  wire logic          arvalid, // Read address valid
   output logic               arready, // Read address ready
   output logic [31:0]        rdata,   // Read data
   output logic [1:0]         rresp,   // Read response
   output logic               rvalid,  // Read data valid
   input  wire logic          rready,  // Read data ready
   input  wire logic          t1_ovf,  // Timer 1 overflow pulse
   input  wire logic          rxd_in,  // Data pin level
   output logic               rxd_out, // Data pin drive value
   output logic               rxd_oe,  // Data pin drive enable
   output logic               txd_out  // Transmit pin / shift clock
);
   typedef enum logic [4:0] {
      TX_IDLE  = 5'h01,
      TX_WAIT  = 5'h02,
      TX_START = 5'h04,
      TX_SEND  = 5'h08,
      TX_FIN   = 5'h10
   } tx_st_t;

   typedef enum logic [4:0] {
      RX_IDLE  = 5'h01,
      RX_ARM   = 5'h02,
      RX_SHIFT = 5'h04,
      RX_FIN   = 5'h08,
      RX_BITS  = 5'h10
   } rx_st_t;

   typedef struct packed {
      logic          awready;
      logic          wready;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          aw_got;
      logic          w_got;
      logic [AW-1:0] waddr;
      logic [7:0]    wbyte;
      logic          wlane;
      logic          arready;
      logic          rvalid;
      logic [1:0]    rresp;
      logic [7:0]    rbyte;
      uart_mode_t    mode;
      logic          mpf;
      logic          ren;
      logic          rb8;
      logic          txf;
      logic          rxf;
      logic          dbl;
      logic [7:0]    rbuf;
      tx_st_t        tst;
      logic [8:0]    tsh;
      logic          tskip;
      rx_st_t        rst;
      logic [8:0]    rsh;
      logic [3:0]    rcnt;
      logic          rlast;
      logic          rsmp;
      logic          rxd_out;
      logic          rxd_oe;
      logic          txd_out;
   } st_t;

   st_t s_r;
   st_t s_nxt;

   logic [2:0] phase;
   logic       tick16;
   logic       tx_roll;
   logic       vote;
   logic       smp_en;

   // One-hot select {power, buffer, control}; zero when unmapped
   function automatic logic [2:0] dec(input logic [AW-1:0] a);
      dec = {a == AW'(OFF_PWR), a == AW'(OFF_BUF), a == AW'(OFF_CTRL)};
   endfunction

   uart_timebase u_tb (
      .aclk    (aclk),
      .aresetn (aresetn),
      .mode    (s_r.mode),
      .dbl     (s_r.dbl),
      .t1_ovf  (t1_ovf),
      .phase   (phase),
      .tick16  (tick16),
      .tx_roll (tx_roll)
   );

   // Three samples per bit time
   assign smp_en = (s_r.rst == RX_BITS) && tick16 &&
                   (s_r.rcnt >= SMP_FIRST) && (s_r.rcnt <= SMP_LAST);

   uart_vote u_vote (
      .aclk    (aclk),
      .aresetn (aresetn),
      .smp_en  (smp_en),
      .rxd     (rxd_in),
      .vote    (vote)
   );

   always_comb begin
      logic [2:0] sel;
      logic [8:0] nsh;
      logic       shift0;
      sel = '0;
      nsh = '0;
      shift0 = 1'b0;
      s_nxt = s_r;

      // Bus: address and data taken in either order
      if (awvalid && s_r.awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.waddr = awaddr;
      end
      if (wvalid && s_r.wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wbyte = wdata[7:0];
         s_nxt.wlane = wstrb[0];
      end
      if (bvalid && bready) begin
         s_nxt.bvalid = 1'b0;
      end
      // Register writes land before hardware sets, so sets win
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
         sel = dec(s_r.waddr);
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = (sel == 3'h0) ? RESP_DEC : RESP_OKAY;
         if (s_r.wlane && sel[0]) begin
            s_nxt.mode = uart_mode_t'(s_r.wbyte[CTRL_MODE +: 2]);
            s_nxt.mpf = s_r.wbyte[CTRL_MPF];
            s_nxt.ren = s_r.wbyte[CTRL_REN];
            s_nxt.rb8 = s_r.wbyte[CTRL_RB8];
            s_nxt.txf = s_r.wbyte[CTRL_TXF];
            s_nxt.rxf = s_r.wbyte[CTRL_RXF];
         end
         if (s_r.wlane && sel[1]) begin
            // Marker 1 above the byte; restarts any frame
            s_nxt.tsh = {1'b1, s_r.wbyte};
            s_nxt.tst = TX_WAIT;
            s_nxt.tskip = 1'b0;
         end
         if (s_r.wlane && sel[2]) begin
            s_nxt.dbl = s_r.wbyte[PWR_DBL];
         end
      end
      s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
      s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;

      // Reads see the receive holding register, not the transmitter
      if (rvalid && rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (arvalid && s_r.arready) begin
         sel = dec(araddr);
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = (sel == 3'h0) ? RESP_DEC : RESP_OKAY;
         s_nxt.rbyte = 8'h00;
         if (sel[0]) begin
            s_nxt.rbyte = {s_r.mode, s_r.mpf, s_r.ren, 1'b0,
                           s_r.rb8, s_r.txf, s_r.rxf};
         end
         if (sel[1]) begin
            s_nxt.rbyte = s_r.rbuf;
         end
         if (sel[2]) begin
            s_nxt.rbyte = {s_r.dbl, 7'h00};
         end
      end
      s_nxt.arready = !s_nxt.rvalid;

      // Transmitter
      unique case (s_r.tst)
         TX_IDLE: begin
            s_nxt.rxd_oe = 1'b0;
         end
         TX_WAIT: begin
            if (s_r.mode == MODE_SHIFT) begin
               // A full machine cycle passes before the gate opens
               if (phase == ST_S6) begin
                  s_nxt.tskip = 1'b1;
                  if (s_r.tskip) begin
                     s_nxt.tst = TX_SEND;
                     s_nxt.rxd_oe = 1'b1;
                     s_nxt.rxd_out = s_r.tsh[0];
                  end
               end
            end else if (tx_roll) begin
               // Bit times follow the counter, not the write
               s_nxt.tst = TX_START;
               s_nxt.txd_out = 1'b0;
            end
         end
         TX_START: begin
            if (tx_roll) begin
               s_nxt.tst = TX_SEND;
               s_nxt.txd_out = s_r.tsh[0];
            end
         end
         TX_SEND: begin
            if (s_r.mode == MODE_SHIFT) begin
               shift0 = (phase == ST_S6);
            end else if (tx_roll) begin
               if (s_r.tsh[8:1] == TX_LAST) begin
                  // Marker would be the stop bit; idle level shows it
                  s_nxt.tst = TX_IDLE;
                  s_nxt.txf = 1'b1;
                  s_nxt.txd_out = 1'b1;
               end else begin
                  s_nxt.tsh = {1'b0, s_r.tsh[8:1]};
                  s_nxt.txd_out = s_r.tsh[1];
               end
            end
         end
         TX_FIN: begin
            if (phase == ST_S1) begin
               s_nxt.tst = TX_IDLE;
               s_nxt.txf = 1'b1;
               s_nxt.rxd_oe = 1'b0;
            end
         end
         default: begin
            s_nxt.tst = TX_IDLE;
         end
      endcase
      if (shift0) begin
         s_nxt.tsh = {1'b0, s_r.tsh[8:1]};
         s_nxt.rxd_out = s_r.tsh[1];
         if (s_r.tsh[8:1] == TX_LAST) begin
            s_nxt.tst = TX_FIN;
         end
      end

      // Receiver; line level kept at every sample tick for edge hunting
      if (tick16) begin
         s_nxt.rlast = rxd_in;
      end
      if (phase == ST_S5) begin
         s_nxt.rsmp = rxd_in;
      end
      unique case (s_r.rst)
         RX_IDLE: begin
            if (s_r.mode == MODE_SHIFT) begin
               if (s_r.ren && !s_r.rxf) begin
                  s_nxt.rst = RX_ARM;
                  s_nxt.rcnt = 4'h0;
               end
            end else if (s_r.ren && tick16 && s_r.rlast && !rxd_in) begin
               s_nxt.rst = RX_BITS;
               s_nxt.rcnt = 4'h0;
               s_nxt.rsh = RX1_PRESET;
            end
         end
         RX_ARM: begin
            if (phase == ST_S6) begin
               s_nxt.rcnt = 4'h1;
               if (s_r.rcnt != 4'h0) begin
                  s_nxt.rsh = {1'b1, RX0_PRESET};
                  s_nxt.rst = RX_SHIFT;
               end
            end
         end
         RX_SHIFT: begin
            if (phase == ST_S6) begin
               nsh = {1'b1, s_r.rsh[6:0], s_r.rsmp};
               s_nxt.rsh = nsh;
               if (!s_r.rsh[7]) begin
                  s_nxt.rbuf = rev8(nsh[7:0]);
                  s_nxt.rst = RX_FIN;
               end
            end
         end
         RX_FIN: begin
            if (phase == ST_S1) begin
               s_nxt.rxf = 1'b1;
               s_nxt.rst = RX_IDLE;
            end
         end
         RX_BITS: begin
            if (tick16) begin
               s_nxt.rcnt = s_r.rcnt + 4'h1;
               if (s_r.rcnt == SMP_DONE) begin
                  nsh = {s_r.rsh[7:0], vote};
                  if (s_r.rsh == RX1_PRESET && vote) begin
                     s_nxt.rst = RX_IDLE;
                  end else if (!s_r.rsh[8]) begin
                     // Older byte is overwritten only via a clear flag
                     if (!s_r.rxf && (!s_r.mpf || vote)) begin
                        s_nxt.rbuf = rev8(nsh[8:1]);
                        s_nxt.rb8 = vote;
                        s_nxt.rxf = 1'b1;
                     end
                     s_nxt.rst = RX_IDLE;
                  end else begin
                     s_nxt.rsh = nsh;
                  end
               end
            end
         end
         default: begin
            s_nxt.rst = RX_IDLE;
         end
      endcase

      // Shift clock: low in S3..S5, computed a state early
      if (s_r.mode == MODE_SHIFT) begin
         s_nxt.txd_out = 1'b1;
         if (s_nxt.tst == TX_SEND || s_nxt.rst == RX_SHIFT) begin
            s_nxt.txd_out =
               !(phase >= ST_S2 && phase <= ST_S4);
         end
      end else if (s_r.tst == TX_IDLE || s_r.tst == TX_WAIT) begin
         if (s_nxt.tst != TX_START) begin
            s_nxt.txd_out = 1'b1;
         end
      end

      if (!aresetn) begin
         s_nxt = '0;
         s_nxt.mode = uart_mode_t'(CTRL_RST[CTRL_MODE +: 2]);
         s_nxt.dbl = PWR_RST[PWR_DBL];
         s_nxt.tst = TX_IDLE;
         s_nxt.rst = RX_IDLE;
         s_nxt.rlast = 1'b1;
         s_nxt.txd_out = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      s_r <= s_nxt;
   end

   assign awready = s_r.awready;
   assign wready  = s_r.wready;
   assign bvalid  = s_r.bvalid;
   assign bresp   = s_r.bresp;
   assign arready = s_r.arready;
   assign rvalid  = s_r.rvalid;
   assign rresp   = s_r.rresp;
   assign rdata   = {24'h00_0000, s_r.rbyte};
   assign rxd_out = s_r.rxd_out;
   assign rxd_oe  = s_r.rxd_oe;
   assign txd_out = s_r.txd_out;
endmodule

//--- src/uart_pkg.sv
package uart_pkg;
   // Register byte offsets
   localparam logic [3:0] OFF_CTRL   = 4'h0;
   localparam logic [3:0] OFF_BUF    = 4'h4;
   localparam logic [3:0] OFF_PWR    = 4'h8;
   // Field positions
   localparam int         CTRL_RXF   = 0;
   localparam int         CTRL_TXF   = 1;
   localparam int         CTRL_RB8   = 2;
   localparam int         CTRL_REN   = 4;
   localparam int         CTRL_MPF   = 5;
   localparam int         CTRL_MODE  = 6;
   localparam int         PWR_DBL    = 7;
   // Reset values
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] PWR_RST    = 8'h00;
   // Machine cycle states S1..S6 as 0..5
   localparam logic [2:0] ST_S1      = 3'h0;
   localparam logic [2:0] ST_S2      = 3'h1;
   localparam logic [2:0] ST_S4      = 3'h3;
   localparam logic [2:0] ST_S5      = 3'h4;
   localparam logic [2:0] ST_S6      = 3'h5;
   // Divide-by-16 counter states
   localparam logic [3:0] SMP_FIRST  = 4'h7;
   localparam logic [3:0] SMP_LAST   = 4'h9;
   localparam logic [3:0] SMP_DONE   = 4'hA;
   localparam logic [3:0] DIV16_LAST = 4'hF;
   // Shift register patterns
   localparam logic [7:0] TX_LAST    = 8'h01;
   localparam logic [7:0] RX0_PRESET = 8'hFE;
   localparam logic [8:0] RX1_PRESET = 9'h1FF;
   // Bus answers
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_DEC   = 2'h3;

   typedef enum logic [1:0] {
      MODE_SHIFT = 2'h0,
      MODE_UART8 = 2'h1,
      MODE_FIX   = 2'h2,
      MODE_VAR   = 2'h3
   } uart_mode_t;

   // Two of three samples decide
   function automatic logic maj3(input logic [2:0] s);
      maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
   endfunction

   // Left-shifted frames arrive first bit at the top
   function automatic logic [7:0] rev8(input logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         rev8[i] = d[7 - i];
      end
   endfunction
endpackage

//--- src/uart_timebase.sv
`timescale 1ns/1ps
module uart_timebase import uart_pkg::*; (
   input  wire logic       aclk,    // CPU clock
   input  wire logic       aresetn, // Sync reset, active low
   input  wire uart_mode_t mode,    // Serial mode
   input  wire logic       dbl,     // rate_double_bit
   input  wire logic       t1_ovf,  // Timer 1 overflow pulse
   output logic [2:0]      phase,   // Machine state, 0 is S1
   output logic            tick16,  // Sixteen times bit rate
   output logic            tx_roll  // Divide-by-16 rollover
);
   typedef struct packed {
      logic [2:0] st;
      logic       pre;
      logic [3:0] div;
      logic       tick;
      logic       roll;
   } tb_t;

   tb_t s_r;
   tb_t s_nxt;

   // One CPU clock per state, six states per machine cycle
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      s_nxt.roll = 1'b0;
      s_nxt.st = (s_r.st == ST_S6) ? ST_S1 : s_r.st + 3'h1;
      // Halving prescaler dropped when doubled
      if (mode == MODE_FIX || (mode != MODE_SHIFT && t1_ovf)) begin
         s_nxt.pre = ~s_r.pre;
         s_nxt.tick = dbl | s_r.pre;
      end
      if (s_nxt.tick) begin
         s_nxt.div = s_r.div + 4'h1;
         s_nxt.roll = (s_r.div == DIV16_LAST);
      end
      if (!aresetn) begin
         s_nxt = '0;
      end
   end

   always_ff @(posedge aclk) begin
      s_r <= s_nxt;
   end

   assign phase   = s_r.st;
   assign tick16  = s_r.tick;
   assign tx_roll = s_r.roll;
endmodule

//--- src/uart_vote.sv
`timescale 1ns/1ps
module uart_vote import uart_pkg::*; (
   input  wire logic aclk,    // CPU clock
   input  wire logic aresetn, // Sync reset, active low
   input  wire logic smp_en,  // Take one sample
   input  wire logic rxd,     // Line level
   output logic      vote     // Majority of last three
);
   typedef struct packed {
      logic [2:0] smp;
   } vt_t;

   vt_t s_r;
   vt_t s_nxt;

   // Keeps the last three samples only
   always_comb begin
      s_nxt = s_r;
      if (smp_en) begin
         s_nxt.smp = {s_r.smp[1:0], rxd};
      end
      if (!aresetn) begin
         s_nxt = '0;
      end
   end

   always_ff @(posedge aclk) begin
      s_r <= s_nxt;
   end

   assign vote = maj3(s_r.smp);
endmodule

//--- verification/uart_engine_chk.sv
`timescale 1ns/1ps
module uart_engine_chk (
   input  wire logic        aclk,    // Clock
   input  wire logic        aresetn, // Reset, low
   input  wire logic        awvalid, // AW valid
   input  wire logic        awready, // AW ready
   input  wire logic        wvalid,  // W valid
   input  wire logic        wready,  // W ready
   input  wire logic [1:0]  bresp,   // B code
   input  wire logic        bvalid,  // B valid
   input  wire logic        bready,  // B ready
   input  wire logic        arvalid, // AR valid
   input  wire logic        arready, // AR ready
   input  wire logic [31:0] rdata,   // R data
   input  wire logic        rvalid,  // R valid
   input  wire logic        rready,  // R ready
   input  wire logic        rxd_oe,  // Data pin enable
   input  wire logic        rxd_out, // Data pin value
   input  wire logic        txd_out  // Serial out
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;

   // Length of the current drive window
   always_comb begin
      cnt_nxt = rxd_oe ? cnt_r + 8'h01 : 8'h00;
   end
   always_ff @(posedge aclk) begin
      cnt_r <= aresetn ? cnt_nxt : 8'h00;
   end

   // Shift clock low for three states, then high
   sequence clk_low_s3_s5;
      !txd_out [*3] ##1 txd_out;
   endsequence
   property shift_clk_shape;
      rxd_oe && $fell(txd_out) |-> clk_low_s3_s5;
   endproperty

   AST_TXD_RESET: assert property ($rose(aresetn) |->
         txd_out && !rxd_oe)
      else $error("serial out not idle after reset");
   AST_SHIFT_CLK: assert property (shift_clk_shape)
      else $error("shift clock low phase not three clocks");
   AST_DATA_S6: assert property (rxd_oe && $changed(rxd_out) |->
         txd_out)
      else $error("data pin moved while shift clock low");
   // Eight machine cycles plus the final state
   AST_OE_LEN: assert property ($fell(rxd_oe) |->
         cnt_r >= 8'h2B && cnt_r <= 8'h37)
      else $error("mode 0 send window length wrong");
   AST_B_LAT: assert property (awvalid && awready && wvalid && wready
         |-> ##2 bvalid)
      else $error("write answer late");
   AST_B_HOLD: assert property (bvalid && !bready |=>
         bvalid && $stable(bresp))
      else $error("write answer dropped");
   AST_R_LAT: assert property (arvalid && arready |=>
         rvalid && rdata[31:8] == 24'h00_0000)
      else $error("read answer late or upper bits set");
   AST_R_HOLD: assert property (rvalid && !rready |=>
         rvalid && $stable(rdata))
      else $error("read answer dropped");
   // Both channels refuse new work while their answer stands
   AST_BUSY: assert property ((rvalid |-> !arready) and
         (bvalid |-> !awready && !wready))
      else $error("new request taken while busy");
endmodule

bind uart_engine uart_engine_chk chk_u (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
   .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
   .rvalid(rvalid), .rready(rready), .rxd_oe(rxd_oe), .rxd_out(rxd_out),
   .txd_out(txd_out));

//--- verification/uart_node.sv
`timescale 1ns/1ps
module uart_node (
   input  wire logic        aclk,    // Clock
   input  wire logic [15:0] bit_cyc, // Clocks per bit
   input  wire logic        send,    // Start a frame
   input  wire logic [9:0]  frame,   // Bits, first at 0
   input  wire logic        txd,     // Line from device
   output logic             line,    // Line to device
   output logic [8:0]       got,     // Stop and data seen
   output int               got_n    // Frames seen
);
   initial begin
      line = 1'b1;
      got = 9'h000;
      got_n = 0;
   end

   // Sender; line released to its pull-up after the frame
   always @(posedge aclk) begin
      if (send) begin
         for (int i = 0; i < 10; i++) begin
            line <= frame[i];
            repeat (bit_cyc) @(posedge aclk);
         end
         line <= 1'b1;
      end
   end

   // Receiver samples mid-bit, start first, LSB next
   always @(negedge txd) begin : rx_blk
      logic [9:0] s;
      repeat (bit_cyc / 2) @(posedge aclk);
      for (int i = 0; i < 10; i++) begin
         s[i] = txd;
         if (i < 9) repeat (bit_cyc) @(posedge aclk);
      end
      got <= s[9:1];
      got_n <= got_n + 1;
   end
endmodule

//--- verification/uart_baud_mode0_mode1_engine_test.sv
`timescale 1ns/1ps
module uart_baud_mode0_mode1_engine_test import uart_pkg::*;;
   logic        aclk, aresetn, t1_ovf, send, tb_rxd, m0, dbl, rxf_m;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        rxd_out, rxd_oe, txd_out, line, rxd_in;
   logic [3:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp, md;
   logic [15:0] bit_cyc;
   logic [9:0]  frame;
   logic [8:0]  got;
   logic [7:0]  r8, rbuf_m;
   logic [16:0] seed;
   int          errors, checks_done, got_n;

   // Pin wire: device drive wins, else node or bench
   assign rxd_in = rxd_oe ? rxd_out : (m0 ? tb_rxd : line);

   uart_engine dut_u (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .t1_ovf(t1_ovf), .rxd_in(rxd_in),
      .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
   uart_node node_u (
      .aclk(aclk), .bit_cyc(bit_cyc), .send(send), .frame(frame),
      .txd(txd_out), .line(line), .got(got), .got_n(got_n));

   // Clock; timer 1 overflows every second clock, no interrupt use
   always #10 aclk = ~aclk;
   always @(posedge aclk) t1_ovf <= ~t1_ovf;

   function automatic logic [16:0] lfsr(input logic [16:0] x);
      return {x[15:0], x[16] ^ x[13]};
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic final_report();
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // A spent wait bound ends the run
   task automatic guard(input int k);
      if (k >= 400) begin
         chk(32'(k), 32'h0);
         final_report();
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d,
                     input logic [1:0] er);
      int k;
      k = 0;
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && k < 400);
      // Response code taken at the handshake edge itself
      guard(k);
      chk(32'(bresp), 32'(er));
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd_reg(input logic [3:0] a, input logic [1:0] er);
      int k;
      k = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && k < 400);
      rd = rdata;
      guard(k);
      chk(32'(rresp), 32'(er));
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   // Send then wait out the frame; model decides what is kept
   task automatic send_frame(input logic [7:0] d, input logic stop,
                             input logic mpf);
      frame <= {stop, d, 1'b0};
      send <= 1'b1;
      @(posedge aclk);
      send <= 1'b0;
      repeat (11 * bit_cyc) @(posedge aclk);
      // A low pulse too short for the mid-bit votes starts nothing
      if (bit_cyc >= 16'h0010 && !rxf_m && (!mpf || stop)) begin
         rbuf_m = d;
         rxf_m = 1'b1;
      end
      rd_reg(OFF_CTRL, RESP_OKAY);
      chk(32'(rd[CTRL_RXF]), 32'(rxf_m));
      if (rxf_m) chk(32'(rd[CTRL_RB8]), 32'h1);
      rd_reg(OFF_BUF, RESP_OKAY);
      chk(rd, {24'h00_0000, rbuf_m});
   endtask

   task automatic tx_byte(input logic [7:0] d);
      int k, n0;
      n0 = got_n;
      k = 0;
      wr(OFF_BUF, d, RESP_OKAY);
      while (got_n == n0 && k < 400) begin
         repeat (8) @(posedge aclk);
         k++;
      end
      guard(k);
      chk(32'(got), {23'h0, 1'b1, d});
      repeat (bit_cyc) @(posedge aclk);
      rd_reg(OFF_CTRL, RESP_OKAY);
      chk(32'(rd[CTRL_TXF]), 32'h1);
      chk(32'(txd_out), 32'h1);
   endtask

   // Mode 0: take data in each clock low phase, drive next bit
   task automatic m0_watch(output logic [7:0] q, input logic [7:0] d);
      int k, j;
      logic p;
      k = 0;
      j = 0;
      p = 1'b1;
      while (j < 8 && k < 400) begin
         @(posedge aclk);
         k++;
         if (p === 1'b1 && txd_out === 1'b0) begin
            q[j] = rxd_out;
            tb_rxd <= d[j];
            j++;
         end
         p = txd_out;
      end
      guard(k);
      repeat (6) @(posedge aclk);
      // Released data line returns to its idle high level
      tb_rxd <= 1'b1;
   endtask

   initial begin
      {aclk, aresetn, t1_ovf, send, m0, awvalid, wvalid} = 7'h00;
      {bready, arvalid, rready, rxf_m} = 4'h0;
      {awaddr, araddr, wdata, frame, rbuf_m} = 58'h0;
      tb_rxd = 1'b1;
      bit_cyc = 16'h0040;
      seed = 17'h1_246D;
      errors = 0;
      checks_done = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // Reset values, unmapped place
      rd_reg(OFF_CTRL, RESP_OKAY);
      chk(rd, 32'(CTRL_RST));
      rd_reg(OFF_PWR, RESP_OKAY);
      chk(rd, 32'(PWR_RST));
      rd_reg(4'hC, RESP_DEC);
      chk(rd, 32'h0);
      wr(4'hC, 8'hFF, RESP_DEC);
      // Modes 1,1,2,2,3 with doubling off, on, off, on, off
      for (int i = 0; i < 5; i++) begin
         md = 2'(i / 2 + 1);
         dbl = i[0];
         bit_cyc <= 16'((md == 2'h2 ? 32 : 64) >> dbl);
         wr(OFF_PWR, {dbl, 7'h00}, RESP_OKAY);
         wr(OFF_CTRL, {md, 6'h10}, RESP_OKAY);
         rxf_m = 1'b0;
         seed = lfsr(seed);
         tx_byte(seed[7:0]);
         seed = lfsr(seed);
         send_frame(seed[7:0], 1'b1, 1'b0);
      end
      seed = lfsr(seed);
      send_frame(seed[7:0], 1'b1, 1'b0);
      wr(OFF_CTRL, {md, 6'h10}, RESP_OKAY);
      rxf_m = 1'b0;
      // Short low pulse must not start a frame
      bit_cyc <= 16'h0004;
      send_frame(8'hFF, 1'b1, 1'b1);
      bit_cyc <= 16'h0040;
      wr(OFF_CTRL, {md, 6'h30}, RESP_OKAY);
      seed = lfsr(seed);
      send_frame(seed[7:0], 1'b0, 1'b1);
      send_frame(seed[15:8], 1'b1, 1'b1);
      // Mode 0 send then receive
      m0 <= 1'b1;
      wr(OFF_CTRL, 8'h00, RESP_OKAY);
      seed = lfsr(seed);
      wr(OFF_BUF, seed[7:0], RESP_OKAY);
      m0_watch(r8, 8'h00);
      chk(32'(r8), 32'(seed[7:0]));
      rd_reg(OFF_CTRL, RESP_OKAY);
      chk(32'(rd[CTRL_TXF]), 32'h1);
      seed = lfsr(seed);
      wr(OFF_CTRL, 8'h10, RESP_OKAY);
      m0_watch(r8, seed[7:0]);
      rd_reg(OFF_CTRL, RESP_OKAY);
      chk(32'(rd[CTRL_RXF]), 32'h1);
      rd_reg(OFF_BUF, RESP_OKAY);
      chk(rd, {24'h00_0000, seed[7:0]});
      final_report();
   end
endmodule
